// ===== logic/asr_pkg.sv
// Purpose: constants and types for the async sram host controller
// Assumes: 200 MHz sys_clk, 5 ns period
// Notes: timing figures kept in ns or us, cycle counts derived from them
package asr_pkg;
   localparam int ADDR_W = 18;
   localparam int DATA_W = 4;
   localparam int CLK_PS = 5000;
   // timing figures in ns or us
   localparam int WRITE_CYCLE_NS = 10;
   localparam int STROBE_LOW_NS = 7;
   localparam int WRITE_DATA_SETUP_NS = 6;
   localparam int WRITE_TURNOFF_DELAY_NS = 5;
   localparam int READ_CYCLE_MIN_NS = 10;
   localparam int ADDRESS_ACCESS_DELAY_NS = 10;
   localparam int OUTPUT_DRIVE_ACCESS_NS = 5;
   localparam int POWER_UP_WAIT_US = 100;
   localparam int RECOVERY_RAMP_US = 50;
   // least times round up to cycles
   function automatic int cyc_up(input int ps);
      cyc_up = (ps + CLK_PS - 1) / CLK_PS;
      if (cyc_up < 1)
      begin
         cyc_up = 1;
      end
   endfunction : cyc_up
   localparam int STROBE_LOW_CYC = cyc_up(STROBE_LOW_NS * 1000);
   localparam int WRITE_CYCLE_CYC = cyc_up(WRITE_CYCLE_NS * 1000);
   localparam int WR_OE_LOW_CYC =
      cyc_up((WRITE_TURNOFF_DELAY_NS + WRITE_DATA_SETUP_NS) * 1000);
   localparam int READ_ACCESS_CYC = cyc_up(ADDRESS_ACCESS_DELAY_NS * 1000) + 1;
   localparam int READ_CYCLE_CYC = cyc_up(READ_CYCLE_MIN_NS * 1000);
   localparam int POWER_UP_CYC = cyc_up(POWER_UP_WAIT_US * 1000000);
   localparam int RECOVERY_CYC = cyc_up(RECOVERY_RAMP_US * 1000000)
      + READ_CYCLE_CYC;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
   // host command toward the controller
   typedef struct packed {
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } asr_cmd_t;
   // sram control pins, all active low
   typedef struct packed {
      logic chip_sel_n;
      logic out_drv_n;
      logic wr_strobe_n;
   } asr_ctl_t;
   localparam asr_ctl_t CTL_IDLE = 3'h7;
   typedef enum logic [2:0] {
      ST_WAIT = 3'h0,
      ST_IDLE = 3'h1,
      ST_WR = 3'h3,
      ST_WR_END = 3'h2,
      ST_RD = 3'h6,
      ST_RD_END = 3'h7,
      ST_RETAIN = 3'h5
   } asr_state_t;
endpackage : asr_pkg

// ===== logic/asr_host.sv
// Purpose: host side controller driving an asynchronous 256k x 4 sram
// Assumes: one 200 MHz clock; sram pins are plain wires to the device
// Notes: data pins are in/out/enable triples, enable low means drive
`timescale 1ns/1ps
module asr_host #(
   parameter int POWER_UP_CYCLES = asr_pkg::POWER_UP_CYC,
   parameter int RECOVERY_CYCLES = asr_pkg::RECOVERY_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire asr_pkg::asr_cmd_t cmd,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic retain_req,
   output logic retain_ack,
   output logic [asr_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid,
   output asr_pkg::asr_ctl_t sram_ctl,
   output logic [asr_pkg::ADDR_W-1:0] address_pin,
   output logic [asr_pkg::DATA_W-1:0] data_pin_out,
   output logic data_pin_oe_n,
   input wire logic [asr_pkg::DATA_W-1:0] data_pin_in
);
   import asr_pkg::*;

   // ************************************************
   // input synchroniser for the data pins
   // ************************************************
   logic [DATA_W-1:0] din_s1_r, din_s2_r, din_s3_r;
   logic [DATA_W-1:0] din_s1_nxt, din_s2_nxt, din_s3_nxt;
   logic din_stable;

   // three stage pipe; second and third agreeing means settled
   always_comb
   begin
      din_s1_nxt = data_pin_in;
      din_s2_nxt = din_s1_r;
      din_s3_nxt = din_s2_r;
      din_stable = (din_s2_r == din_s3_r);
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         din_s1_r <= '0;
         din_s2_r <= '0;
         din_s3_r <= '0;
      end
      else
      begin
         din_s1_r <= din_s1_nxt;
         din_s2_r <= din_s2_nxt;
         din_s3_r <= din_s3_nxt;
      end
   end

   // ************************************************
   // access sequencer
   // ************************************************
   asr_state_t st_r, st_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   asr_ctl_t ctl_r, ctl_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [DATA_W-1:0] dout_r, dout_nxt, rdat_r, rdat_nxt;
   logic oe_n_r, oe_n_nxt, rdv_r, rdv_nxt, rdy_r, rdy_nxt, ack_r, ack_nxt;
   // a pin sample reaches the third sync flop two edges after it is taken
   localparam int SYNC_LAT = 2;
   // idle tail after the strobes rise, clamped so it never wraps the counter
   localparam int WR_TAIL_CYC = (WRITE_CYCLE_CYC > STROBE_LOW_CYC) ?
      WRITE_CYCLE_CYC - STROBE_LOW_CYC - 1 : 0;

   // count helpers
   function automatic logic [CNT_W-1:0] to_cnt(input int n);
      to_cnt = CNT_W'(n);
   endfunction : to_cnt

   // next state and pin values
   always_comb
   begin
      st_nxt = st_r;
      cnt_nxt = (cnt_r == CNT_ZERO) ? CNT_ZERO : cnt_r - CNT_ONE;
      ctl_nxt = ctl_r;
      addr_nxt = addr_r;
      dout_nxt = dout_r;
      rdat_nxt = rdat_r;
      oe_n_nxt = oe_n_r;
      rdv_nxt = 1'b0;
      rdy_nxt = 1'b0;
      ack_nxt = ack_r;
      case (st_r)
         ST_WAIT:
         begin
            // power up or recovery wait, chip deselected
            ctl_nxt = CTL_IDLE;
            if (cnt_r == CNT_ZERO)
            begin
               st_nxt = ST_IDLE;
               rdy_nxt = 1'b1;
            end
         end
         ST_IDLE:
         begin
            rdy_nxt = 1'b1;
            if (retain_req)
            begin
               // deselect before the supply drops
               ctl_nxt = CTL_IDLE;
               st_nxt = ST_RETAIN;
               ack_nxt = 1'b1;
               rdy_nxt = 1'b0;
            end
            else if (cmd_valid)
            begin
               // address and data captured as the strobes fall
               addr_nxt = cmd.addr;
               rdy_nxt = 1'b0;
               if (cmd.write)
               begin
                  dout_nxt = cmd.wdata;
                  oe_n_nxt = 1'b0;
                  ctl_nxt = '{chip_sel_n: 1'b0, out_drv_n: 1'b1, wr_strobe_n: 1'b0};
                  cnt_nxt = to_cnt(STROBE_LOW_CYC - 1);
                  st_nxt = ST_WR;
               end
               else
               begin
                  ctl_nxt = '{chip_sel_n: 1'b0, out_drv_n: 1'b0, wr_strobe_n: 1'b1};
                  // sample taken after the access time, seen after the sync stages
                  cnt_nxt = to_cnt(READ_ACCESS_CYC + SYNC_LAT);
                  st_nxt = ST_RD;
               end
            end
         end
         ST_WR:
         begin
            // address and data held steady while strobes low
            if (cnt_r == CNT_ZERO)
            begin
               ctl_nxt = CTL_IDLE;
               cnt_nxt = to_cnt(WR_TAIL_CYC);
               st_nxt = ST_WR_END;
            end
         end
         ST_WR_END:
         begin
            // data held one cycle past the rising strobe
            oe_n_nxt = 1'b1;
            if (cnt_r == CNT_ZERO)
            begin
               st_nxt = ST_IDLE;
               rdy_nxt = 1'b1;
            end
         end
         ST_RD:
         begin
            if (cnt_r == CNT_ZERO && din_stable)
            begin
               rdat_nxt = din_s3_r;
               rdv_nxt = 1'b1;
               ctl_nxt = CTL_IDLE;
               st_nxt = ST_RD_END;
               cnt_nxt = to_cnt(READ_CYCLE_CYC - 1);
            end
         end
         ST_RD_END:
         begin
            // device bus release before any next drive
            if (cnt_r == CNT_ZERO)
            begin
               st_nxt = ST_IDLE;
               rdy_nxt = 1'b1;
            end
         end
         ST_RETAIN:
         begin
            ctl_nxt = CTL_IDLE;
            if (!retain_req)
            begin
               ack_nxt = 1'b0;
               cnt_nxt = to_cnt(RECOVERY_CYCLES);
               st_nxt = ST_WAIT;
            end
         end
         default:
         begin
            st_nxt = ST_WAIT;
            ctl_nxt = CTL_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         st_r <= ST_WAIT;
         cnt_r <= to_cnt(POWER_UP_CYCLES);
         ctl_r <= CTL_IDLE;
         addr_r <= '0;
         dout_r <= '0;
         rdat_r <= '0;
         oe_n_r <= 1'b1;
         rdv_r <= 1'b0;
         rdy_r <= 1'b0;
         ack_r <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
         cnt_r <= cnt_nxt;
         ctl_r <= ctl_nxt;
         addr_r <= addr_nxt;
         dout_r <= dout_nxt;
         rdat_r <= rdat_nxt;
         oe_n_r <= oe_n_nxt;
         rdv_r <= rdv_nxt;
         rdy_r <= rdy_nxt;
         ack_r <= ack_nxt;
      end
   end

   // outputs straight from flops
   assign cmd_ready = rdy_r;
   assign retain_ack = ack_r;
   assign rd_data = rdat_r;
   assign rd_valid = rdv_r;
   assign sram_ctl = ctl_r;
   assign address_pin = addr_r;
   assign data_pin_out = dout_r;
   assign data_pin_oe_n = oe_n_r;
endmodule : asr_host

// ===== verification/asr_sram_model.sv
// Purpose: behavioural async sram on the far side of the host controller
// Assumes: no clock; fixed 6 ns access time
// Notes: a released bus shows the inverse of its last value
`timescale 1ns/1ps
module asr_sram_model
(
   input wire asr_pkg::asr_ctl_t sram_ctl,
   input wire logic [asr_pkg::ADDR_W-1:0] address_pin,
   input wire logic [asr_pkg::DATA_W-1:0] data_pin_out,
   input wire logic data_pin_oe_n,
   output logic [asr_pkg::DATA_W-1:0] data_pin_in
);
   import asr_pkg::*;
   localparam int SLOTS = 16;
   logic [DATA_W-1:0] mem_d [SLOTS];
   logic [ADDR_W-1:0] mem_a [SLOTS];
   logic mem_v [SLOTS];
   logic [DATA_W-1:0] rd_q = 4'h0;
   logic drv;
   // slot hit only on a full address match; unwritten words read as 6
   function automatic logic [DATA_W-1:0] lookup(input logic [ADDR_W-1:0] a);
      lookup = (mem_v[a[3:0]] === 1'b1 && mem_a[a[3:0]] == a) ? mem_d[a[3:0]] : 4'h6;
   endfunction : lookup
   // store while select and strobe overlap low
   always @*
      if (!sram_ctl.chip_sel_n && !sram_ctl.wr_strobe_n)
      begin
         mem_d[address_pin[3:0]] = data_pin_out;
         mem_a[address_pin[3:0]] = address_pin;
         mem_v[address_pin[3:0]] = 1'b1;
      end
   // drive only in a read; released on deselect or output drive high
   assign drv = !sram_ctl.chip_sel_n && !sram_ctl.out_drv_n
      && sram_ctl.wr_strobe_n;
   // access delay inside the bound
   always @(address_pin or drv)
      rd_q <= #6 lookup(address_pin);
   // wire level from both parties
   assign data_pin_in = !data_pin_oe_n ? data_pin_out : drv ? rd_q : ~rd_q;
endmodule : asr_sram_model

// ===== verification/asr_host_chk.sv
// Purpose: pin timing checks on the sram host controller
// Assumes: one clock, sync active high reset
// Notes: bound into asr_host
`timescale 1ns/1ps
module asr_host_chk #(
   parameter int POWER_UP_CYCLES = asr_pkg::POWER_UP_CYC,
   parameter int RECOVERY_CYCLES = asr_pkg::RECOVERY_CYC
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic cmd_ready,
   input wire logic retain_ack,
   input wire logic rd_valid,
   input wire asr_pkg::asr_ctl_t sram_ctl,
   input wire logic [asr_pkg::ADDR_W-1:0] address_pin,
   input wire logic [asr_pkg::DATA_W-1:0] data_pin_out,
   input wire logic data_pin_oe_n
);
   import asr_pkg::*;
   int pu_cnt;
   int rec_cnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // cycles since reset and since the end of retention
   always_ff @(posedge sys_clk)
   begin
      pu_cnt <= rst ? 0 : (pu_cnt < 1000000) ? pu_cnt + 1 : pu_cnt;
      rec_cnt <= rst ? RECOVERY_CYCLES : retain_ack ? 0 :
         (rec_cnt < 1000000) ? rec_cnt + 1 : rec_cnt;
   end
   sequence s_wr_hold;
      !sram_ctl.wr_strobe_n ##1 !sram_ctl.wr_strobe_n;
   endsequence
   a_write_pins: assert property (!sram_ctl.wr_strobe_n |-> !sram_ctl.chip_sel_n
      && sram_ctl.out_drv_n && !data_pin_oe_n) else $error("write pins wrong");
   a_write_stable: assert property (s_wr_hold |-> $stable(address_pin)
      && $stable(data_pin_out)) else $error("write address or data moved");
   a_strobe_width: assert property ($fell(sram_ctl.wr_strobe_n) |-> s_wr_hold)
      else $error("write strobe too short");
   a_select_width: assert property ($fell(sram_ctl.chip_sel_n)
      |-> !sram_ctl.chip_sel_n[*2]) else $error("select too short");
   a_read_shape: assert property (!sram_ctl.out_drv_n |-> sram_ctl.wr_strobe_n
      && !sram_ctl.chip_sel_n && data_pin_oe_n) else $error("read pins wrong");
   a_read_access: assert property (rd_valid |-> sram_ctl.out_drv_n
      && $past(!sram_ctl.out_drv_n) && $past(!sram_ctl.out_drv_n, 3)) else $error("read short");
   a_retain_park: assert property (retain_ack |-> sram_ctl == CTL_IDLE && !cmd_ready)
      else $error("retention not parked");
   a_power_wait: assert property (!sram_ctl.chip_sel_n |-> pu_cnt >= POWER_UP_CYCLES)
      else $error("access before power up wait");
   a_recover_wait: assert property (!sram_ctl.chip_sel_n |-> rec_cnt >= RECOVERY_CYCLES)
      else $error("access before recovery");
endmodule : asr_host_chk
bind asr_host asr_host_chk #(.POWER_UP_CYCLES(POWER_UP_CYCLES), .RECOVERY_CYCLES(RECOVERY_CYCLES))
   i_chk (.sys_clk(sys_clk), .rst(rst), .cmd_ready(cmd_ready), .retain_ack(retain_ack),
   .rd_valid(rd_valid), .sram_ctl(sram_ctl), .address_pin(address_pin),
   .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n));

// ===== verification/asr_host_tb.sv
// Purpose: self-checking bench for the sram host controller
// Assumes: 200 MHz clock, shortened power-up and recovery counts
// Notes: sram model answers on the far side
`timescale 1ns/1ps
module asr_host_tb;
   import asr_pkg::*;
   localparam int PU = 10;
   localparam int RC = 5;
   localparam int LIM = 2000;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   asr_cmd_t cmd = '0;
   logic cmd_valid = 1'b0;
   logic retain_req = 1'b0;
   logic cmd_ready, retain_ack, rd_valid, data_pin_oe_n;
   logic [DATA_W-1:0] rd_data, data_pin_out, data_pin_in;
   logic [ADDR_W-1:0] address_pin;
   asr_ctl_t sram_ctl;
   int fail_count = 0;
   int check_count = 0;
   int n;
   logic [ADDR_W-1:0] adr [4] = '{18'h00000, 18'h3FFFF, 18'h15555, 18'h2AAAA};
   logic [DATA_W-1:0] dat [4] = '{4'h5, 4'hA, 4'hF, 4'h0};
   asr_host #(.POWER_UP_CYCLES(PU), .RECOVERY_CYCLES(RC)) i_dut (.sys_clk(sys_clk), .rst(rst),
      .cmd(cmd), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .retain_req(retain_req),
      .retain_ack(retain_ack), .rd_data(rd_data), .rd_valid(rd_valid), .sram_ctl(sram_ctl),
      .address_pin(address_pin), .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n),
      .data_pin_in(data_pin_in));
   asr_sram_model i_mem (.sram_ctl(sram_ctl), .address_pin(address_pin),
      .data_pin_out(data_pin_out), .data_pin_oe_n(data_pin_oe_n), .data_pin_in(data_pin_in));
   initial forever #2.5 sys_clk = ~sys_clk;
   task automatic test_done();
      if (fail_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : test_done
   task automatic chk_data(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      check_count++;
      if (got !== exp)
      begin
         fail_count++;
         $display("mismatch at %0t: data %h, expected %h", $time, got, exp);
      end
   endtask : chk_data
   task automatic chk_flag(input logic ok, input string what);
      check_count++;
      if (ok !== 1'b1)
      begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask : chk_flag
   // edges until ready, ack or read valid is seen, bounded
   task automatic wait_hi(input int sel);
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while ((sel == 0 ? cmd_ready : sel == 1 ? retain_ack : rd_valid) !== 1'b1 && n < LIM);
      if (n >= LIM)
      begin
         fail_count++;
         $display("mismatch at %0t: timeout waiting on handshake %0d", $time, sel);
         test_done();
      end
   endtask : wait_hi
   task automatic issue(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      cmd <= {wr, a, d};
      cmd_valid <= 1'b1;
      wait_hi(0);
      // drop valid and let an edge pass before any next request
      cmd_valid <= 1'b0;
      @(posedge sys_clk);
   endtask : issue
   task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
      issue(1'b0, a, 4'h0);
      wait_hi(2);
      chk_data(rd_data, exp);
   endtask : rd_chk
   // back-to-back writes at corner addresses, then reads in reverse
   task automatic t_write_read();
      for (int i = 0; i < 4; i++)
         issue(1'b1, adr[i], dat[i]);
      for (int i = 3; i >= 0; i--)
         rd_chk(adr[i], dat[i]);
   endtask : t_write_read
   // a request while busy is dropped, not queued
   task automatic t_refused();
      issue(1'b1, adr[0], 4'h9);
      cmd <= {1'b1, adr[2], 4'h3};
      cmd_valid <= 1'b1;
      @(posedge sys_clk);
      cmd_valid <= 1'b0;
      @(posedge sys_clk);
      rd_chk(adr[2], dat[2]);
      rd_chk(adr[0], 4'h9);
   endtask : t_refused
   // park for retention, then recover and read back
   task automatic t_retain();
      retain_req <= 1'b1;
      wait_hi(1);
      chk_flag(sram_ctl === CTL_IDLE, "not parked");
      retain_req <= 1'b0;
      wait_hi(0);
      chk_flag(n > RC, "recovery too short");
      rd_chk(adr[1], dat[1]);
   endtask : t_retain
   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      wait_hi(0);
      chk_flag(n > PU, "ready before power up wait");
      t_write_read();
      t_refused();
      t_retain();
      test_done();
   end
endmodule : asr_host_tb
